// [rtl/clock_generator_lock_power.sv]
// Design decision made here: strobed register access.
`timescale 1ns/100ps
// Overview of operation
// - Code 1010 selects frame clock input 0
// - Code 1100 selects frame clock input 2
// - Frame clock input 3 selectable, code 1101
// - Code 1110 selects recovered receiver frame clock
// - Lock status bit 0 reports generator 3 lock
// - Power register zero at reset, all disabled
// - Bit 12 powers the precision generator
// - Blocks on generator 3 halt while disabled
// - Bit 11 powers the second generator
// - Generator 2 clock pins drive low when off
// - Blocks on generator 2 halt while disabled
// - Bit 10 gates generator 1, pins low
module clock_generator_lock_power #(
  parameter int unsigned TIMEOUT_CYC = clkgen_pkg::REF_TIMEOUT_CYC,
  parameter int unsigned LOCK_PERIODS = clkgen_pkg::LOCK_PERIODS,
  parameter int unsigned TOL_CYC      = clkgen_pkg::PERIOD_TOL_CYC,
  parameter int unsigned BIT_HALF     = clkgen_pkg::BIT_HALF_CYC,
  parameter int unsigned HALF_FRAME   = clkgen_pkg::BITS_HALF_FRAME
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_b_i,
  input  wire clkgen_pkg::reg_req_t reg_req_i,
  output logic [15:0]               reg_rdata_o,
  input  wire logic [3:0]           frame_clock_input_n_i,
  input  wire logic                 spdif_frame_clock_i,
  input  wire logic                 lower_ref_i,
  output clkgen_pkg::gen_clk_t      gen_clk_o [3],
  output logic [2:0]                gen_run_o,
  output logic [9:0]                periph_power_on_o,
  output logic                      precision_generator_locked_o,
  output logic                      irq_o
);

  localparam int unsigned CNT_W   = $clog2(TIMEOUT_CYC + 2);
  localparam int unsigned MATCH_W = $clog2(LOCK_PERIODS + 1);
  localparam int unsigned BIT_W   = $clog2(BIT_HALF + 1);
  localparam int unsigned HF_W    = $clog2(HALF_FRAME + 1);

  // Refuse settings the counters cannot serve
  if (TIMEOUT_CYC < 4 || LOCK_PERIODS < 1 || BIT_HALF < 1 || HALF_FRAME < 1) begin : g_chk
    $error("clock_generator_lock_power: parameter out of range");
  end

  // Tolerance must stay below the timeout or a dead reference could match
  if (TOL_CYC >= TIMEOUT_CYC) begin : g_chk_tol
    $error("clock_generator_lock_power: tolerance not below timeout");
  end

  // Software-visible registers
  logic [3:0]                    ref_sel_r;
  logic [15:0]                   power_r;
  logic [clkgen_pkg::IRQ_W-1:0]  irq_stat_r;
  logic [clkgen_pkg::IRQ_W-1:0]  irq_mask_r;

  // Lock tracker and period measurement
  clkgen_pkg::lock_state_t       lock_st_r;
  clkgen_pkg::lock_state_t       lock_st_nxt;
  logic [CNT_W-1:0]              period_cnt_r;
  logic [CNT_W-1:0]              last_period_r;
  logic [MATCH_W-1:0]            match_cnt_r;
  logic                          have_edge_r;
  logic                          ref_prev_r;

  // Combinational helpers
  logic                          ref_level;
  logic                          ref_rise;
  logic                          timeout;
  logic                          period_ok;
  logic                          gen3_on;
  logic                          sel_wr;
  logic                          gen3_off_wr;
  logic                          ev_gained;
  logic                          ev_lost;
  logic [CNT_W-1:0]              period_diff;

  // Decoded enables and register strobes
  assign gen3_on = power_r[clkgen_pkg::PWR_GEN3_BIT];
  assign sel_wr  = reg_req_i.wr && (reg_req_i.addr == clkgen_pkg::OFS_REF_SELECT);

  // Power write clearing bit 12; lock drops at the same edge as the bit
  assign gen3_off_wr = reg_req_i.wr && (reg_req_i.addr == clkgen_pkg::OFS_POWER_ENABLE) &&
                       !reg_req_i.wdata[clkgen_pkg::PWR_GEN3_BIT];

  // Reference source mux; codes outside this set come from the lower selector
  always_comb begin
    unique case (ref_sel_r)
      clkgen_pkg::REF_CODE_FRAME_IN0: ref_level = frame_clock_input_n_i[0];
      clkgen_pkg::REF_CODE_FRAME_IN2: ref_level = frame_clock_input_n_i[2];
      clkgen_pkg::REF_CODE_FRAME_IN3: ref_level = frame_clock_input_n_i[3];
      clkgen_pkg::REF_CODE_SPDIF:     ref_level = spdif_frame_clock_i;
      default:                        ref_level = lower_ref_i;
    endcase
  end

  // Rising edge of the reference and period comparison
  assign ref_rise = ref_level && !ref_prev_r;
  assign timeout  = (period_cnt_r >= CNT_W'(TIMEOUT_CYC));
  assign period_diff = (period_cnt_r > last_period_r) ? (period_cnt_r - last_period_r)
                                                      : (last_period_r - period_cnt_r);
  assign period_ok = have_edge_r && (period_diff <= CNT_W'(TOL_CYC));

  // Edge history of the chosen reference
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ref_prev_r <= 1'b0;
    end else begin
      ref_prev_r <= ref_level;
    end
  end

  // Period measurement; clears at the timeout so a dead reference cannot wrap to a match
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      period_cnt_r  <= '0;
      last_period_r <= '0;
      have_edge_r   <= 1'b0;
      match_cnt_r   <= '0;
    end else if (!gen3_on || sel_wr || timeout) begin
      // Any of these invalidates past periods, so acquisition starts over
      period_cnt_r  <= '0;
      last_period_r <= '0;
      have_edge_r   <= 1'b0;
      match_cnt_r   <= '0;
    end else if (ref_rise) begin
      period_cnt_r  <= '0;
      last_period_r <= period_cnt_r;
      have_edge_r   <= 1'b1;
      if (!period_ok) begin
        match_cnt_r <= '0;
      end else if (match_cnt_r != MATCH_W'(LOCK_PERIODS)) begin
        match_cnt_r <= match_cnt_r + MATCH_W'(1);
      end
    end else begin
      period_cnt_r  <= period_cnt_r + CNT_W'(1);
    end
  end

  // Lock tracker next state
  always_comb begin
    lock_st_nxt = lock_st_r;
    unique case (lock_st_r)
      clkgen_pkg::LK_OFF: begin
        if (gen3_on) begin
          lock_st_nxt = clkgen_pkg::LK_ACQUIRE;
        end
      end
      clkgen_pkg::LK_ACQUIRE: begin
        if (!gen3_on || gen3_off_wr) begin
          lock_st_nxt = clkgen_pkg::LK_OFF;
        end else if (!sel_wr && !timeout && ref_rise && period_ok &&
                     match_cnt_r == MATCH_W'(LOCK_PERIODS - 1)) begin
          lock_st_nxt = clkgen_pkg::LK_LOCKED;
        end
      end
      clkgen_pkg::LK_LOCKED: begin
        if (!gen3_on || gen3_off_wr) begin
          lock_st_nxt = clkgen_pkg::LK_OFF;
        end else if (sel_wr || timeout || (ref_rise && !period_ok)) begin
          lock_st_nxt = clkgen_pkg::LK_ACQUIRE;
        end
      end
      default: lock_st_nxt = clkgen_pkg::LK_OFF;
    endcase
  end

  // Lock events for the sticky status bits
  assign ev_gained = (lock_st_nxt == clkgen_pkg::LK_LOCKED) &&
                     (lock_st_r != clkgen_pkg::LK_LOCKED);
  assign ev_lost   = (lock_st_nxt != clkgen_pkg::LK_LOCKED) &&
                     (lock_st_r == clkgen_pkg::LK_LOCKED);

  // Lock tracker state and its status flop
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_st_r                    <= clkgen_pkg::LK_OFF;
      precision_generator_locked_o <= clkgen_pkg::LOCK_STATUS_RST[clkgen_pkg::LOCK_BIT];
    end else begin
      lock_st_r                    <= lock_st_nxt;
      precision_generator_locked_o <= (lock_st_nxt == clkgen_pkg::LK_LOCKED);
    end
  end

  // Software writes to configuration registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ref_sel_r  <= clkgen_pkg::REF_SELECT_RST[clkgen_pkg::REF_SEL_LSB +: clkgen_pkg::REF_SEL_W];
      power_r    <= clkgen_pkg::POWER_ENABLE_RST;
      irq_mask_r <= clkgen_pkg::IRQ_MASK_RST;
    end else if (reg_req_i.wr) begin
      unique case (reg_req_i.addr)
        clkgen_pkg::OFS_REF_SELECT: begin
          ref_sel_r <= reg_req_i.wdata[clkgen_pkg::REF_SEL_LSB +: clkgen_pkg::REF_SEL_W];
        end
        clkgen_pkg::OFS_POWER_ENABLE: begin
          power_r <= reg_req_i.wdata & clkgen_pkg::POWER_WRITE_MASK;
        end
        clkgen_pkg::OFS_IRQ_MASK: begin
          irq_mask_r <= reg_req_i.wdata[clkgen_pkg::IRQ_W-1:0];
        end
        default: ;
      endcase
    end
  end

  // Sticky events; a new event beats a write-one-to-clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r[clkgen_pkg::IRQ_GAINED_BIT] <= ev_gained ||
        (irq_stat_r[clkgen_pkg::IRQ_GAINED_BIT] &&
         !(reg_req_i.wr && reg_req_i.addr == clkgen_pkg::OFS_IRQ_STATUS &&
           reg_req_i.wdata[clkgen_pkg::IRQ_GAINED_BIT]));
      irq_stat_r[clkgen_pkg::IRQ_LOST_BIT] <= ev_lost ||
        (irq_stat_r[clkgen_pkg::IRQ_LOST_BIT] &&
         !(reg_req_i.wr && reg_req_i.addr == clkgen_pkg::OFS_IRQ_STATUS &&
           reg_req_i.wdata[clkgen_pkg::IRQ_LOST_BIT]));
    end
  end

  // Interrupt level follows the flops one cycle behind
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Read data stand only in the cycle after the read strobe
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= '0;
    end else if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        clkgen_pkg::OFS_REF_SELECT:   reg_rdata_o <= {12'h000, ref_sel_r};
        clkgen_pkg::OFS_LOCK_STATUS: begin
          reg_rdata_o <= {15'h0000, precision_generator_locked_o};
        end
        clkgen_pkg::OFS_POWER_ENABLE: reg_rdata_o <= power_r;
        clkgen_pkg::OFS_IRQ_STATUS:   reg_rdata_o <= {14'h0000, irq_stat_r};
        clkgen_pkg::OFS_IRQ_MASK:     reg_rdata_o <= {14'h0000, irq_mask_r};
        default:                      reg_rdata_o <= '0;
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

  // Run enables for blocks clocked by each generator
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gen_run_o         <= '0;
      periph_power_on_o <= '0;
    end else begin
      gen_run_o[0]      <= power_r[clkgen_pkg::PWR_GEN1_BIT];
      gen_run_o[1]      <= power_r[clkgen_pkg::PWR_GEN2_BIT];
      gen_run_o[2]      <= gen3_on;
      periph_power_on_o <= power_r[clkgen_pkg::PWR_PERIPH_W-1:0];
    end
  end

  // Three generators; index 2 realigns its frame to the reference once locked
  for (genvar g = 0; g < 3; g++) begin : g_gen
    logic             en;
    logic             align;
    logic [BIT_W-1:0] bit_cnt_r;
    logic [HF_W-1:0]  hf_cnt_r;

    // Each generator follows its own power bit
    if (g == 0) begin : g_en1
      assign en = power_r[clkgen_pkg::PWR_GEN1_BIT];
    end else if (g == 1) begin : g_en2
      assign en = power_r[clkgen_pkg::PWR_GEN2_BIT];
    end else begin : g_en3
      assign en = gen3_on;
    end

    // Only the precision generator tracks its reference
    if (g == 2) begin : g_al
      assign align = ref_rise && (lock_st_r == clkgen_pkg::LK_LOCKED);
    end else begin : g_noal
      assign align = 1'b0;
    end

    // Disabled generator holds both clocks low, so assigned pins sit low
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        bit_cnt_r    <= '0;
        hf_cnt_r     <= '0;
        gen_clk_o[g] <= '0;
      end else if (!en) begin
        bit_cnt_r    <= '0;
        hf_cnt_r     <= '0;
        gen_clk_o[g] <= '0;
      end else if (align) begin
        bit_cnt_r    <= '0;
        hf_cnt_r     <= '0;
        gen_clk_o[g] <= '{frame: 1'b1, bitclk: 1'b0};
      end else if (bit_cnt_r == BIT_W'(BIT_HALF - 1)) begin
        bit_cnt_r           <= '0;
        gen_clk_o[g].bitclk <= !gen_clk_o[g].bitclk;
        // Frame edges fall on bit clock falling edges
        if (gen_clk_o[g].bitclk) begin
          if (hf_cnt_r == HF_W'(HALF_FRAME - 1)) begin
            hf_cnt_r           <= '0;
            gen_clk_o[g].frame <= !gen_clk_o[g].frame;
          end else begin
            hf_cnt_r <= hf_cnt_r + HF_W'(1);
          end
        end
      end else begin
        bit_cnt_r <= bit_cnt_r + BIT_W'(1);
      end
    end
  end

endmodule

// [rtl/clkgen_pkg.sv]
package clkgen_pkg;

  // Register port geometry
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;

  // Register offsets
  localparam logic [15:0] OFS_REF_SELECT   = 16'hF026;
  localparam logic [15:0] OFS_LOCK_STATUS  = 16'hF027;
  localparam logic [15:0] OFS_POWER_ENABLE = 16'hF050;
  localparam logic [15:0] OFS_IRQ_STATUS   = 16'hF0F0;
  localparam logic [15:0] OFS_IRQ_MASK     = 16'hF0F1;

  // Field positions
  localparam int unsigned REF_SEL_LSB      = 0;
  localparam int unsigned REF_SEL_W        = 4;
  localparam int unsigned LOCK_BIT         = 0;
  localparam int unsigned PWR_GEN1_BIT     = 10;
  localparam int unsigned PWR_GEN2_BIT     = 11;
  localparam int unsigned PWR_GEN3_BIT     = 12;
  localparam int unsigned PWR_PERIPH_W     = 10;
  localparam int unsigned IRQ_GAINED_BIT   = 0;
  localparam int unsigned IRQ_LOST_BIT     = 1;
  localparam int unsigned IRQ_W            = 2;

  // Writable bits; everything else reads zero
  localparam logic [15:0] POWER_WRITE_MASK = 16'h1FFF;

  // Reset values
  localparam logic [15:0] REF_SELECT_RST   = 16'h0000;
  localparam logic [15:0] LOCK_STATUS_RST  = 16'h0000;
  localparam logic [15:0] POWER_ENABLE_RST = 16'h0000;
  localparam logic [1:0]  IRQ_MASK_RST     = 2'h0;

  // Reference select codes
  localparam logic [3:0] REF_CODE_FRAME_IN0 = 4'hA;
  localparam logic [3:0] REF_CODE_FRAME_IN2 = 4'hC;
  localparam logic [3:0] REF_CODE_FRAME_IN3 = 4'hD;
  localparam logic [3:0] REF_CODE_SPDIF     = 4'hE;

  // Timing
  localparam int unsigned CLK_FREQ_HZ     = 50_000_000;
  localparam int unsigned REF_TIMEOUT_US  = 1000;
  localparam int unsigned REF_TIMEOUT_CYC = (CLK_FREQ_HZ / 1_000_000) * REF_TIMEOUT_US;
  localparam int unsigned LOCK_PERIODS    = 4;
  localparam int unsigned PERIOD_TOL_CYC  = 2;
  localparam int unsigned BIT_HALF_CYC    = 8;
  localparam int unsigned BITS_HALF_FRAME = 32;

  // Lock tracker states
  typedef enum logic [2:0] {
    LK_OFF     = 3'b001,
    LK_ACQUIRE = 3'b010,
    LK_LOCKED  = 3'b100
  } lock_state_t;

  // Register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // Clock pair of one generator
  typedef struct packed {
    logic frame;
    logic bitclk;
  } gen_clk_t;

endpackage

// [test/clock_generator_lock_power_asserts.sv]
`timescale 1ns/100ps
// Checks the register port, power gating and lock from the top ports only
module clock_generator_lock_power_chk (
  input  wire logic                 clk_i,
  input  wire logic                 rst_b_i,
  input  wire clkgen_pkg::reg_req_t reg_req_i,
  input  wire logic [15:0]          reg_rdata_o,
  input  wire clkgen_pkg::gen_clk_t gen_clk_o [3],
  input  wire logic [2:0]           gen_run_o,
  input  wire logic [9:0]           periph_power_on_o,
  input  wire logic                 precision_generator_locked_o,
  input  wire logic                 irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // Decoded requests; exact address match only
  wire wr_pwr  = reg_req_i.wr && reg_req_i.addr == clkgen_pkg::OFS_POWER_ENABLE;
  wire wr_sel  = reg_req_i.wr && reg_req_i.addr == clkgen_pkg::OFS_REF_SELECT;
  wire wr_msk  = reg_req_i.wr && reg_req_i.addr == clkgen_pkg::OFS_IRQ_MASK;
  wire rd_pwr  = reg_req_i.rd && reg_req_i.addr == clkgen_pkg::OFS_POWER_ENABLE;
  wire rd_lock = reg_req_i.rd && reg_req_i.addr == clkgen_pkg::OFS_LOCK_STATUS;

  periph_write_a: assert property (wr_pwr |-> ##2
    periph_power_on_o == $past(reg_req_i.wdata[9:0], 2)) else $error("peripheral enables stale");
  rdata_idle_a: assert property (!$past(reg_req_i.rd) |-> reg_rdata_o == 16'h0000)
    else $error("read data not zero outside read");
  lock_read_a: assert property ($past(rd_lock) |->
    reg_rdata_o == {15'h0000, $past(precision_generator_locked_o)}) else $error("lock read wrong");
  power_read_a: assert property ($past(rd_pwr) |-> reg_rdata_o[15:13] == 3'h0 &&
    reg_rdata_o[12:10] == gen_run_o && reg_rdata_o[9:0] == periph_power_on_o)
    else $error("power read wrong");
  select_drop_a: assert property (wr_sel |-> ##[1:2] !precision_generator_locked_o)
    else $error("lock kept after reference change");
  gen3_off_a: assert property (wr_pwr && !reg_req_i.wdata[12] |-> ##2 (!gen_run_o[2] &&
    gen_clk_o[2] == 2'h0 && !precision_generator_locked_o)) else $error("generator 3 still on");
  gen2_off_a: assert property (wr_pwr && !reg_req_i.wdata[11] |-> ##2
    (!gen_run_o[1] && gen_clk_o[1] == 2'h0)) else $error("generator 2 still on");
  gen1_off_a: assert property (wr_pwr && !reg_req_i.wdata[10] |-> ##2
    (!gen_run_o[0] && gen_clk_o[0] == 2'h0)) else $error("generator 1 still on");
  lock_power_a: assert property ($rose(precision_generator_locked_o) |-> gen_run_o[2])
    else $error("lock while generator 3 off");
  irq_mask_a: assert property (wr_msk && reg_req_i.wdata[1:0] == 2'h0 |-> ##2 !irq_o)
    else $error("interrupt while fully masked");

  // Main scenarios reached
  cover property ($rose(precision_generator_locked_o));
  cover property ($rose(irq_o));
  cover property ($past(rd_lock) && reg_rdata_o[0]);
endmodule

bind clock_generator_lock_power clock_generator_lock_power_chk u_chk (
  .clk_i                        (clk_i),
  .rst_b_i                      (rst_b_i),
  .reg_req_i                    (reg_req_i),
  .reg_rdata_o                  (reg_rdata_o),
  .gen_clk_o                    (gen_clk_o),
  .gen_run_o                    (gen_run_o),
  .periph_power_on_o            (periph_power_on_o),
  .precision_generator_locked_o (precision_generator_locked_o),
  .irq_o                        (irq_o)
);

// [test/clock_generator_lock_power_tb.sv]
`timescale 1ns/100ps
module clock_generator_lock_power_tb;
  logic                 clk_i     = 1'b0;
  logic                 rst_b_i   = 1'b0;
  clkgen_pkg::reg_req_t req       = '0;
  logic [3:0]           frame_in  = 4'h0;
  logic                 spdif     = 1'b0;
  logic                 lower_ref = 1'b0;
  logic [7:0]           cnt       = 8'h00;
  int                   src       = 7;
  int                   bad_count = 0;
  int                   compares  = 0;
  logic [15:0]          rdata;
  logic [15:0]          d;
  clkgen_pkg::gen_clk_t gclk [3];
  logic [2:0]           run;
  logic [9:0]           periph;
  logic                 locked;
  logic                 irq;
  logic                 seen;
  logic [3:0]           codes [5] = '{4'hA, 4'hC, 4'hD, 4'hE, 4'h0};
  int                   srcs [5]  = '{0, 2, 3, 4, 5};

  always #10 clk_i = ~clk_i;

  // Only the chosen source toggles, period 16 cycles, well inside the timeout
  always @(posedge clk_i) begin
    cnt       <= cnt + 8'h01;
    frame_in  <= (src < 4) ? (4'(cnt[3]) << src) : 4'h0;
    spdif     <= (src == 4) && cnt[3];
    lower_ref <= (src == 5) && cnt[3];
  end

  // Small timeout keeps the run short
  clock_generator_lock_power #(.TIMEOUT_CYC(64)) DUT (
    .clk_i                        (clk_i),
    .rst_b_i                      (rst_b_i),
    .reg_req_i                    (req),
    .reg_rdata_o                  (rdata),
    .frame_clock_input_n_i        (frame_in),
    .spdif_frame_clock_i          (spdif),
    .lower_ref_i                  (lower_ref),
    .gen_clk_o                    (gclk),
    .gen_run_o                    (run),
    .periph_power_on_o            (periph),
    .precision_generator_locked_o (locked),
    .irq_o                        (irq)
  );

  task automatic summarize();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bus cycles: strobes one cycle, read data only in the cycle after
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clk_i);
    req.addr  <= a;
    req.wdata <= v;
    req.wr    <= 1'b1;
    @(posedge clk_i);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge clk_i);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk_i);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    chk(v, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Bounded wait; running out ends the run with a mismatch
  task automatic wait_lock(input logic exp);
    for (int i = 0; i < 400 && locked !== exp; i++) cyc(1);
    chk(16'(locked), 16'(exp));
    if (locked !== exp) summarize();
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    #1 chk({1'b0, run, periph, locked, irq}, 16'h0000);
    chk(16'({gclk[0], gclk[1], gclk[2]}), 16'h0000);
    rdchk(16'hF027, 16'h0000);
    rdchk(16'hF050, 16'h0000);
    $display("test reset done");
    wr(16'hF050, 16'hFFFF);
    rdchk(16'hF050, 16'h1FFF);
    chk(16'(periph), 16'h03FF);
    chk(16'(run), 16'h0007);
    wr(16'hF027, 16'hFFFF);
    rdchk(16'hF027, 16'h0000);
    rdchk(16'hF100, 16'h0000);
    $display("test registers done");
    // Wrong source first: a lock there would mean a bad decode
    for (int k = 0; k < 5; k++) begin
      src <= 1;
      wr(16'hF026, {12'h000, codes[k]});
      rdchk(16'hF026, {12'h000, codes[k]});
      cyc(120);
      chk(16'(locked), 16'h0000);
      src <= srcs[k];
      wait_lock(1'b1);
    end
    rdchk(16'hF027, 16'h0001);
    $display("test reference codes done");
    chk(16'(irq), 16'h0000);
    wr(16'hF0F1, 16'h0001);
    cyc(2);
    chk(16'(irq), 16'h0001);
    wr(16'hF0F1, 16'h0000);
    cyc(2);
    chk(16'(irq), 16'h0000);
    rd(16'hF0F0, d);
    chk(d, 16'h0003);
    wr(16'hF0F1, 16'h0001);
    wr(16'hF0F0, 16'hFFFF);
    cyc(2);
    chk(16'(irq), 16'h0000);
    rdchk(16'hF0F0, 16'h0000);
    $display("test interrupt done");
    wr(16'hF050, 16'h0800);
    cyc(2);
    chk(16'({locked, run, gclk[2]}), 16'h0008);
    rdchk(16'hF027, 16'h0000);
    rdchk(16'hF0F0, 16'h0002);
    seen = 1'b0;
    repeat (40) begin
      cyc(1);
      seen |= gclk[1].bitclk;
    end
    chk(16'(seen), 16'h0001);
    wr(16'hF050, 16'h0000);
    cyc(2);
    seen = 1'b0;
    repeat (40) begin
      cyc(1);
      seen |= |{run, gclk[1], gclk[0]};
    end
    chk(16'(seen), 16'h0000);
    wr(16'hF050, 16'h1000);
    wait_lock(1'b1);
    seen = 1'b0;
    repeat (40) begin
      cyc(1);
      seen |= gclk[2].bitclk;
    end
    chk(16'(seen), 16'h0001);
    $display("test power gating done");
    summarize();
  end
endmodule
